// >>> bench/armc_conv_model.sv
//==============================================================
// Purpose: Behavioural converter feeding status and results
// Assumes: Bench loads new values in the mclk domain
// Notes: Values stand until the next load, like a real result
`timescale 1ns/1ps
`default_nettype none
module armc_conv_model (
	// Clock
	input wire logic mclk,
	// Load request from the bench
	input wire logic ld,
	input wire logic [7:0] st_in,
	input wire logic [23:0] res_in,
	// Converter outputs
	output logic [7:0] conv_status = 8'h00,
	output logic [23:0] conv_result = 24'h000000
);
	// Latch a new condition and result only on request
	always @(posedge mclk) begin
		if (ld) begin
			conv_status <= st_in;
			conv_result <= res_in;
		end
	end
endmodule : armc_conv_model
`default_nettype wire

// >>> bench/testbench.sv
//==============================================================
// Purpose: Self-checking bench for the converter register bank
// Assumes: One AHB-Lite master, one slave, single word transfers
// Notes: Read data is checked by a monitor against a queue
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import armc_pkg::*;
	localparam logic [7:0] TB_ID = 8'h3c; // Arbitrary value
	// Bus, converter and scoreboard state
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, ld = 1'b0, dph = 1'b0;
	logic [7:0] st_in = 8'h00;
	logic [23:0] res_in = 24'h0;
	logic [7:0] conv_status, mode_out, ctrl_out, port_out, update_rate_word;
	logic [23:0] conv_result;
	logic [31:0] exp_q[$];
	logic [31:0] v;
	logic [31:0] wv [11];
	logic [3:0] sel_tab [11] = '{ARMC_SEL_MODE, ARMC_SEL_CTRL, ARMC_SEL_FILT,
		ARMC_SEL_PORT, 4'h5, 4'h6, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd};
	int n_fail = 0;
	int samples_checked = 0;
	// 25 MHz clock
	initial begin
		forever #20 mclk = ~mclk;
	end
	armc_regs #(.ID_CODE(TB_ID)) armc_regs_inst (.mclk(mclk), .rst_n(rst_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.conv_status(conv_status), .conv_result(conv_result),
		.mode_out(mode_out), .ctrl_out(ctrl_out), .port_out(port_out),
		.update_rate_word(update_rate_word));
	armc_conv_model armc_conv_model_inst (.mclk(mclk), .ld(ld),
		.st_in(st_in), .res_in(res_in), .conv_status(conv_status),
		.conv_result(conv_result));
	// Data phase of a read: compare with the oldest note
	always @(posedge mclk) begin
		if (dph) begin
			samples_checked++;
			if (exp_q.size() == 0)
				exp_q.push_back(32'hx);
			if (hrdata !== exp_q[0]) begin
				n_fail++;
				$display("unexpected hrdata: expected %h seen %h", exp_q[0], hrdata);
			end
			if (hresp !== 1'b0) begin
				n_fail++;
				$display("unexpected hresp: expected 0 seen %b", hresp);
			end
			exp_q.delete(0);
		end
		dph <= hsel && htrans[1] && !hwrite && hreadyout;
	end
	task automatic give_verdict;
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	// Bounded wait for hready at a rising edge
	task automatic wait_rdy;
		int n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (hreadyout !== 1'b1) begin
			n_fail++;
			$display("unexpected hready: expected 1 seen %b", hreadyout);
			give_verdict();
		end
	endtask : wait_rdy
	// One single word transfer; a read notes its expectation
	task automatic xfer(input logic [7:0] a, input logic wr,
		input logic [31:0] d, input logic [31:0] e);
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		hsel <= 1'b1;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= d;
		if (!wr)
			exp_q.push_back(e);
		wait_rdy();
	endtask : xfer
	// Command write, then one word through the transfer window
	task automatic put(input logic [3:0] s, input logic [31:0] d);
		xfer(ARMC_OFF_CMD, 1'b1, {28'h0, s}, 32'h0);
		xfer(ARMC_OFF_XFER, 1'b1, d, 32'h0);
	endtask : put
	task automatic get(input logic [3:0] s, input logic [31:0] e);
		xfer(ARMC_OFF_CMD, 1'b1, {24'h0, 4'h4, s}, 32'h0);
		xfer(ARMC_OFF_XFER, 1'b0, 32'h0, e);
	endtask : get
	// Port register keeps only its pin bits; cal words are 24 bits
	function automatic logic [31:0] msk(input logic [3:0] s, input logic rd);
		if (s >= 4'h5 && s != ARMC_SEL_PORT)
			return 32'hffffff;
		return (rd && s == ARMC_SEL_PORT) ? 32'h33 : 32'hff;
	endfunction : msk
	task automatic chk(input string nm, input logic [7:0] s,
		input logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// Reset, then the reset values must stand
	task automatic do_reset(input int n);
		rst_n <= 1'b0;
		repeat (n) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		chk("update_rate_word", update_rate_word, ARMC_RST_FILT);
		xfer(ARMC_OFF_XFER, 1'b0, 32'h0, 32'h0);
		get(ARMC_SEL_MODE, {24'h0, ARMC_RST_MODE});
	endtask : do_reset
	initial begin
		void'($urandom(32'h42214333));
		do_reset(16);
		get(ARMC_SEL_CTRL, {24'h0, ARMC_RST_CTRL});
		get(ARMC_SEL_PORT, {24'h0, ARMC_RST_PORT});
		get(ARMC_SEL_FILT, {24'h0, ARMC_RST_FILT});
		get(ARMC_SEL_TEST, 32'h0); // read only, never written
		// Write every slot first so shared storage would show up
		foreach (sel_tab[k]) begin
			wv[k] = $urandom & msk(sel_tab[k], 1'b0);
			put(sel_tab[k], wv[k]);
		end
		foreach (sel_tab[k]) begin
			get(sel_tab[k], wv[k] & msk(sel_tab[k], 1'b1));
		end
		chk("mode_out", mode_out, wv[0][7:0]);
		chk("ctrl_out", ctrl_out, wv[1][7:0]);
		chk("update_rate_word", update_rate_word, wv[2][7:0]);
		chk("port_out", port_out, wv[3][7:0] & 8'h33);
		// A stray window write changes nothing once the pair is done
		xfer(ARMC_OFF_XFER, 1'b1, ~wv[0], 32'h0);
		get(ARMC_SEL_MODE, wv[0]);
		xfer(ARMC_OFF_XFER, 1'b0, 32'h0, 32'h0);
		// Direct word reads must agree with the command path
		xfer(ARMC_OFF_CTRL, 1'b0, 32'h0, wv[1]);
		xfer(ARMC_OFF_PORT, 1'b0, 32'h0, wv[3] & 32'h33);
		xfer(ARMC_OFF_FILT, 1'b0, 32'h0, wv[2]);
		xfer(ARMC_OFF_CMD, 1'b0, 32'h0, 32'h0);
		// A second command while one is armed is dropped
		xfer(ARMC_OFF_CMD, 1'b1, {28'h0, ARMC_SEL_MODE}, 32'h0);
		xfer(ARMC_OFF_PHASE, 1'b0, 32'h0, 32'h1);
		xfer(ARMC_OFF_CMD, 1'b1,
			{24'h0, 4'h4, ARMC_SEL_CTRL}, 32'h0);
		xfer(ARMC_OFF_XFER, 1'b1, ~wv[0], 32'h0);
		xfer(ARMC_OFF_MODE, 1'b0, 32'h0, ~wv[0] & 32'hff);
		chk("mode_out", mode_out, ~wv[0][7:0]);
		// New converter values; wait out the status synchroniser
		v = $urandom;
		ld <= 1'b1;
		st_in <= v[7:0];
		res_in <= v[31:8];
		@(posedge mclk);
		ld <= 1'b0;
		repeat (4) @(posedge mclk);
		put(ARMC_SEL_STATUS, {24'h0, ~v[7:0]});
		put(ARMC_SEL_DATA, {8'h0, ~v[31:8]});
		put(ARMC_SEL_ID, {24'h0, ~TB_ID});
		get(ARMC_SEL_STATUS, {24'h0, v[7:0]});
		get(ARMC_SEL_DATA, {8'h0, v[31:8]});
		get(ARMC_SEL_ID, {24'h0, TB_ID});
		xfer(ARMC_OFF_STATUS, 1'b0, 32'h0, {24'h0, v[7:0]});
		xfer(ARMC_OFF_DATA, 1'b0, 32'h0, {8'h0, v[31:8]});
		xfer(ARMC_OFF_ID, 1'b0, 32'h0, {24'h0, TB_ID});
		do_reset(2);
		give_verdict();
	end
endmodule : testbench
`default_nettype wire

// >>> core/armc_regs.sv
//==============================================================
// Purpose: Command-driven register bank of a sigma-delta converter
// Assumes: AHB-Lite single word transfers, zero wait states
// Notes: Software writes a command, then moves one word at XFER
// How it works
// [RULE1] Host opens each access with a command; the direct word offsets also serve reads with no command
// [RULE2] Reset leaves block waiting for command
// [RULE3] Status is read only, writes ignored
// [RULE4] Mode register readable and writable
// [RULE5] Channel control register readable and writable
// [RULE6] Port control configures two digital pins
// [RULE7] Filter word sets the update rate
// [RULE8] Data register holds latest result
// [RULE9] Five offset registers, pseudo channels share; code reaches only two (selects 5 and 6)
// [RULE10] Five gain registers, shared the same way
// [RULE11] Host leaves test registers alone
// [RULE12] Read-only identification register
// [RULE13] Set means one, cleared means zero
// [RULE14] Command is eight bit write only
// [RULE15] Filter resets to 45 hex
// [RULE16] After data transfer, wait for command
// [RULE17] Writes to read-only targets are ignored
`timescale 1ns/1ps
`default_nettype none
module armc_regs
	import armc_pkg::*;
#(
	parameter logic [7:0] ID_CODE = 8'h5a // Arbitrary value
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Converter side
	input wire logic [7:0] conv_status,
	input wire logic [23:0] conv_result,
	output logic [7:0] mode_out,
	output logic [7:0] ctrl_out,
	output logic [7:0] port_out,
	output logic [7:0] update_rate_word
);
	//==========================================================
	// Bus address phase capture
	armc_aphase_t ap_r, ap_nxt; // Pending data phase
	logic [31:0] hrdata_r, hrdata_nxt; // Registered read data
	always_comb begin
		ap_nxt.valid = hsel && hready && htrans[1];
		ap_nxt.write = hwrite;
		ap_nxt.addr = haddr[7:0];
	end
	//==========================================================
	// Register state
	armc_phase_t phase_r, phase_nxt; // Command protocol phase
	logic [7:0] cmd_r, cmd_nxt; // Last accepted command word
	logic [7:0] mode_r, mode_nxt;
	logic [7:0] ctrl_r, ctrl_nxt;
	logic [7:0] port_r, port_nxt;
	logic [7:0] filt_r, filt_nxt;
	logic [7:0] stat_r, stat_nxt; // Synchronised status
	logic [7:0] stat_s1_r; // First synchroniser stage
	logic [23:0] ofs_r [ARMC_NCAL];
	logic [23:0] gain_r [ARMC_NCAL];
	logic [23:0] data_r, data_nxt;
	logic [3:0] sel; // Register selected by the command
	logic cmd_rd; // Command asks for a read
	logic wr_data, wr_cmd, rd_data;
	logic [2:0] cal_idx; // Shared calibration slot
	always_comb begin
		sel = cmd_r[3:0];
		cmd_rd = cmd_r[ARMC_CMD_RD_BIT]; // One means read [RULE13]
		wr_cmd = ap_r.valid && ap_r.write && ap_r.addr == ARMC_OFF_CMD;
		wr_data = ap_r.valid && ap_r.write && ap_r.addr == ARMC_OFF_XFER
			&& phase_r == ARMC_WAIT_DATA && !cmd_rd; // [RULE1]
		rd_data = ap_nxt.valid && !hwrite
			&& haddr[7:0] == ARMC_OFF_XFER
			&& phase_r == ARMC_WAIT_DATA && cmd_rd;
		// Pseudo-differential channels fold onto five gain slots, two offset slots [RULE9]
		cal_idx = (sel >= ARMC_SEL_GAIN0) ?
			3'(sel - ARMC_SEL_GAIN0) : 3'(sel - ARMC_SEL_OFS0);
	end
	//==========================================================
	// Protocol phase and configuration writes
	always_comb begin
		phase_nxt = phase_r;
		cmd_nxt = cmd_r;
		mode_nxt = mode_r;
		ctrl_nxt = ctrl_r;
		port_nxt = port_r;
		filt_nxt = filt_r;
		if (wr_cmd && phase_r == ARMC_WAIT_CMD) begin
			cmd_nxt = hwdata[7:0]; // Eight bit command [RULE14]
			phase_nxt = ARMC_WAIT_DATA;
		end else if (wr_data || rd_data) begin
			phase_nxt = ARMC_WAIT_CMD; // [RULE16]
		end
		if (wr_data) begin
			if (sel == ARMC_SEL_MODE) begin
				mode_nxt = hwdata[7:0]; // [RULE4]
			end else if (sel == ARMC_SEL_CTRL) begin
				ctrl_nxt = hwdata[7:0]; // [RULE5]
			end else if (sel == ARMC_SEL_PORT) begin
				port_nxt = hwdata[7:0] & 8'h33; // [RULE6]
			end else if (sel == ARMC_SEL_FILT) begin
				filt_nxt = hwdata[7:0]; // [RULE7]
			end
			// Status, data and ID fall through [RULE3] [RULE17]
		end
	end
	// Status is captured across two flops, result through one flop
	always_comb begin
		stat_nxt = stat_s1_r;
		data_nxt = conv_result; // [RULE8]
	end
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			phase_r <= ARMC_WAIT_CMD; // [RULE2]
			cmd_r <= 8'h00;
			mode_r <= ARMC_RST_MODE;
			ctrl_r <= ARMC_RST_CTRL;
			port_r <= ARMC_RST_PORT;
			filt_r <= ARMC_RST_FILT; // [RULE15]
			stat_s1_r <= 8'h00;
			stat_r <= 8'h00;
			data_r <= 24'h000000;
			ap_r <= '0;
			hrdata_r <= 32'h00000000;
		end else begin
			phase_r <= phase_nxt;
			cmd_r <= cmd_nxt;
			mode_r <= mode_nxt;
			ctrl_r <= ctrl_nxt;
			port_r <= port_nxt;
			filt_r <= filt_nxt;
			stat_s1_r <= conv_status;
			stat_r <= stat_nxt;
			data_r <= data_nxt;
			ap_r <= ap_nxt;
			hrdata_r <= hrdata_nxt;
		end
	end
	//==========================================================
	// Calibration banks, one generate entry per slot
	for (genvar i = 0; i < ARMC_NCAL; i++) begin : g_cal
		logic ofs_we, gain_we;
		always_comb begin
			ofs_we = wr_data && sel >= ARMC_SEL_OFS0
				&& sel < ARMC_SEL_PORT && cal_idx == 3'(i);
			gain_we = wr_data && sel >= ARMC_SEL_GAIN0
				&& sel < ARMC_SEL_TEST && cal_idx == 3'(i);
		end
		always_ff @(posedge mclk) begin
			if (!rst_n) begin
				ofs_r[i] <= ARMC_RST_CAL;
				gain_r[i] <= ARMC_RST_CAL;
			end else begin
				if (ofs_we) ofs_r[i] <= hwdata[23:0]; // [RULE9]
				if (gain_we) gain_r[i] <= hwdata[23:0]; // [RULE10]
			end
		end
	end
	//==========================================================
	// Read mux, evaluated in the address phase
	logic [23:0] xfer_val; // Value of the selected register
	always_comb begin
		xfer_val = 24'h000000;
		if (sel == ARMC_SEL_STATUS) begin
			xfer_val = {16'h0000, stat_r};
		end else if (sel == ARMC_SEL_MODE) begin
			xfer_val = {16'h0000, mode_r};
		end else if (sel == ARMC_SEL_CTRL) begin
			xfer_val = {16'h0000, ctrl_r};
		end else if (sel == ARMC_SEL_FILT) begin
			xfer_val = {16'h0000, filt_r};
		end else if (sel == ARMC_SEL_DATA) begin
			xfer_val = data_r;
		end else if (sel == ARMC_SEL_PORT) begin
			xfer_val = {16'h0000, port_r};
		end else if (sel == ARMC_SEL_ID) begin
			xfer_val = {16'h0000, ID_CODE}; // [RULE12]
		end else if (sel >= ARMC_SEL_GAIN0 && sel < ARMC_SEL_TEST) begin
			xfer_val = gain_r[cal_idx];
		end else if (sel >= ARMC_SEL_OFS0 && sel < ARMC_SEL_PORT) begin
			xfer_val = ofs_r[cal_idx];
		end
		// Test slot reads zero; host is expected to leave it [RULE11]
	end
	always_comb begin
		hrdata_nxt = 32'h00000000;
		if (ap_nxt.valid && !hwrite) begin
			if (haddr[7:0] == ARMC_OFF_STATUS) begin
				hrdata_nxt = {24'h000000, stat_r};
			end else if (haddr[7:0] == ARMC_OFF_MODE) begin
				hrdata_nxt = {24'h000000, mode_r};
			end else if (haddr[7:0] == ARMC_OFF_CTRL) begin
				hrdata_nxt = {24'h000000, ctrl_r};
			end else if (haddr[7:0] == ARMC_OFF_PORT) begin
				hrdata_nxt = {24'h000000, port_r};
			end else if (haddr[7:0] == ARMC_OFF_FILT) begin
				hrdata_nxt = {24'h000000, filt_r};
			end else if (haddr[7:0] == ARMC_OFF_DATA) begin
				hrdata_nxt = {8'h00, data_r};
			end else if (haddr[7:0] == ARMC_OFF_ID) begin
				hrdata_nxt = {24'h000000, ID_CODE};
			end else if (haddr[7:0] == ARMC_OFF_XFER && rd_data) begin
				hrdata_nxt = {8'h00, xfer_val};
			end else if (haddr[7:0] == ARMC_OFF_PHASE) begin
				hrdata_nxt = {24'h000000, cmd_r[7:1],
					phase_r == ARMC_WAIT_DATA};
			end
			// Command word is write only and reads zero [RULE14]
		end
	end
	//==========================================================
	// Outputs: zero wait states, always OKAY
	always_comb begin
		hrdata = hrdata_r;
		hreadyout = 1'b1;
		hresp = 1'b0;
		mode_out = mode_r;
		ctrl_out = ctrl_r;
		port_out = port_r;
		update_rate_word = filt_r;
	end
	//==========================================================
	// Checks
	sequence s_cmd_taken;
		wr_cmd && phase_r == ARMC_WAIT_CMD;
	endsequence
	// A command arriving while one is armed must not replace it
	sequence s_cmd_late;
		wr_cmd && phase_r == ARMC_WAIT_DATA;
	endsequence
	// Either direction of the window access closes the pair
	sequence s_xfer_done;
		wr_data || rd_data;
	endsequence
	AST_CMD_ARMS: assert property (@(posedge mclk) // [RULE14]
		disable iff (!rst_n) s_cmd_taken |=> phase_r == ARMC_WAIT_DATA)
		else $error("command did not arm data phase");
	AST_CMD_KEEP: assert property (@(posedge mclk) // [RULE14]
		disable iff (!rst_n) s_cmd_late |=> $stable(cmd_r))
		else $error("armed command was replaced");
	AST_RESET_WAIT: assert property (@(posedge mclk) // [RULE2]
		!rst_n |=> phase_r == ARMC_WAIT_CMD)
		else $error("reset did not return to command wait");
	AST_IDLE_READ: assert property (@(posedge mclk) // [RULE2]
		disable iff (!rst_n) ap_nxt.valid && !hwrite
		&& haddr[7:0] == ARMC_OFF_XFER && phase_r == ARMC_WAIT_CMD
		|=> hrdata == 32'h00000000)
		else $error("window read without command returned data");
	AST_BACK_TO_CMD: assert property (@(posedge mclk) // [RULE16]
		disable iff (!rst_n) s_xfer_done |=> phase_r == ARMC_WAIT_CMD)
		else $error("data transfer did not end transaction");
	AST_FILT_RESET: assert property (@(posedge mclk) // [RULE15]
		!rst_n |=> filt_r == ARMC_RST_FILT)
		else $error("filter reset value wrong");
	AST_MODE_WR: assert property (@(posedge mclk) // [RULE4]
		disable iff (!rst_n) wr_data && sel == ARMC_SEL_MODE
		|=> mode_r == $past(hwdata[7:0]))
		else $error("mode write lost");
	AST_CTRL_WR: assert property (@(posedge mclk) // [RULE5]
		disable iff (!rst_n) wr_data && sel == ARMC_SEL_CTRL
		|=> ctrl_r == $past(hwdata[7:0]))
		else $error("control write lost");
	AST_FILT_WR: assert property (@(posedge mclk) // [RULE7]
		disable iff (!rst_n) wr_data && sel == ARMC_SEL_FILT
		|=> update_rate_word == $past(hwdata[7:0]))
		else $error("filter write lost");
	AST_RO_KEEP: assert property (@(posedge mclk) // [RULE17]
		disable iff (!rst_n) wr_data && (sel == ARMC_SEL_STATUS
		|| sel == ARMC_SEL_DATA || sel == ARMC_SEL_ID)
		|=> $stable(mode_r) && $stable(ctrl_r) && $stable(filt_r)
		&& $stable(port_r))
		else $error("read-only write changed state");
	AST_OKAY: assert property (@(posedge mclk) disable iff (!rst_n)
		hreadyout && !hresp) else $error("bus answer not OKAY");
endmodule : armc_regs
`default_nettype wire

// >>> shared/armc_pkg.sv
//==============================================================
// Purpose: Constants and types for the converter register bank
// Assumes: AHB-Lite slave, 32-bit words, one register per word
// Notes: Offsets are byte addresses of aligned words
package armc_pkg;
	// Register word offsets (byte addresses)
	localparam logic [7:0] ARMC_OFF_CMD = 8'h00;
	localparam logic [7:0] ARMC_OFF_STATUS = 8'h04;
	localparam logic [7:0] ARMC_OFF_MODE = 8'h08;
	localparam logic [7:0] ARMC_OFF_CTRL = 8'h0c;
	localparam logic [7:0] ARMC_OFF_PORT = 8'h10;
	localparam logic [7:0] ARMC_OFF_FILT = 8'h14;
	localparam logic [7:0] ARMC_OFF_DATA = 8'h18;
	localparam logic [7:0] ARMC_OFF_ID = 8'h1c;
	localparam logic [7:0] ARMC_OFF_XFER = 8'h20;
	localparam logic [7:0] ARMC_OFF_PHASE = 8'h24;
	// Register select codes in the command word (low nibble)
	localparam logic [3:0] ARMC_SEL_STATUS = 4'h0;
	localparam logic [3:0] ARMC_SEL_MODE = 4'h1;
	localparam logic [3:0] ARMC_SEL_CTRL = 4'h2;
	localparam logic [3:0] ARMC_SEL_FILT = 4'h3;
	localparam logic [3:0] ARMC_SEL_DATA = 4'h4;
	localparam logic [3:0] ARMC_SEL_OFS0 = 4'h5;
	localparam logic [3:0] ARMC_SEL_GAIN0 = 4'h9;
	localparam logic [3:0] ARMC_SEL_PORT = 4'h7;
	localparam logic [3:0] ARMC_SEL_ID = 4'hf;
	localparam logic [3:0] ARMC_SEL_TEST = 4'he;
	// Command word fields
	localparam int ARMC_CMD_RD_BIT = 6;
	// Reset values
	localparam logic [7:0] ARMC_RST_MODE = 8'h00;
	localparam logic [7:0] ARMC_RST_CTRL = 8'h07;
	localparam logic [7:0] ARMC_RST_PORT = 8'h00;
	localparam logic [7:0] ARMC_RST_FILT = 8'h45;
	localparam logic [23:0] ARMC_RST_CAL = 24'h000000;
	// Number of calibration register pairs
	localparam int ARMC_NCAL = 5;
	// Transaction phase of the command protocol
	typedef enum logic {ARMC_WAIT_CMD, ARMC_WAIT_DATA} armc_phase_t;
	// AHB address phase captured for the data phase
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
	} armc_aphase_t;
endpackage : armc_pkg
